// ---- hdl/hp_smbus_pkg.sv ----
// Constants, encodings and timing for the hot-plug expander SMBus master.
// Assumes a 40 MHz core clock and a single-master bus to one EEPROM and one expander.
//
// Notes on behaviour
// - Any hot-plug output change triggers one expander write carrying all outputs.
// - An asserted expander interrupt triggers one read of all hot-plug inputs.
// - Hot-plug handling covers downstream ports 1 to 23; port 0 is excluded.
// - The master has no multi-master arbitration and no arbitration-loss detection.
// - After reset, configuration values are loaded from the EEPROM over defaults.
// - The master bus has its own pins, independent of the slave bus.
// - Names ending in _n are active low, as is the interrupt on gpio8_in; all others active high.
// - Expander interrupt pin function is selectable by software or EEPROM data.
// - The bus clock is driven only during EEPROM or expander accesses.
// - Expander interrupt is the first alternate input function of GPIO pin 8.
package hp_smbus_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int         CLK_PERIOD_NS   = 25;
  localparam int         BUS_BIT_TIME_NS = 10000;
  localparam logic [7:0] QTR_CYC         = 8'(BUS_BIT_TIME_NS / (4 * CLK_PERIOD_NS));

  // ****************************************************************
  // Byte engine commands
  // ****************************************************************
  localparam logic [1:0] CMD_START = 2'h0;
  localparam logic [1:0] CMD_STOP  = 2'h1;
  localparam logic [1:0] CMD_WR    = 2'h2;
  localparam logic [1:0] CMD_RD    = 2'h3;

  // ****************************************************************
  // Slave addresses, command bytes and reset values
  // ****************************************************************
  localparam logic [6:0]  EE_ADDR      = 7'h50;
  localparam logic [7:0]  EE_OFFSET    = 8'h00;
  localparam logic [6:0]  EXP_ADDR     = 7'h20;
  localparam logic [7:0]  EXP_CMD_IN   = 8'h00;
  localparam logic [7:0]  EXP_CMD_OUT  = 8'h02;
  localparam logic [31:0] CFG_DEFAULT  = 32'h0000_0000;
  localparam int          CFG_IRQ_BIT  = 0;
  localparam logic [22:0] HP_RESET     = 23'h00_0000;

  // ****************************************************************
  // Sequence lengths (index of the closing stop step)
  // ****************************************************************
  localparam logic [3:0] EE_LAST = 4'h9;
  localparam logic [3:0] WR_LAST = 4'h6;
  localparam logic [3:0] RD_LAST = 4'h8;

  // Main sequencer states, Gray coded along boot, load, idle, write, read.
  typedef enum logic [2:0] {
    M_BOOT = 3'b000,
    M_EE   = 3'b001,
    M_IDLE = 3'b011,
    M_WR   = 3'b010,
    M_RD   = 3'b110
  } main_st_t;

endpackage : hp_smbus_pkg

// ---- hdl/smbus_byte_engine.sv ----
// Bit-level SMBus master engine: start, stop, byte write and byte read.
// Assumes open-drain pins resolved outside; bus clock and data inputs pass a two-flop synchroniser.
`timescale 1ns/1ps
module smbus_byte_engine
  import hp_smbus_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       arst_n_in,
  // Command side
  input  wire logic       cmd_valid_in,
  input  wire logic [1:0] cmd_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       rd_nack_in,
  output logic            busy_out,
  output logic            done_out,
  output logic [7:0]      rdata_out,
  output logic            ack_bit_out,
  // Bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            scl_oe_out,
  output logic            sda_oe_out
);

  typedef enum logic [1:0] {E_IDLE = 2'b00, E_START = 2'b01, E_BIT = 2'b11, E_STOP = 2'b10} eng_st_t;

  typedef struct packed {
    eng_st_t    st;
    logic [1:0] q;
    logic [7:0] cnt;
    logic [3:0] bitn;
    logic [8:0] tx;
    logic [8:0] rx;
    logic       scl_oe;
    logic       sda_oe;
    logic       done;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
  } eng_t;

  eng_t r, n;

  // ****************************************************************
  // Next state: quarter-bit sequencing with clock stretching.
  // ****************************************************************
  always_comb
  begin
    n       = r;
    n.done  = 1'b0;
    n.scl_s = {r.scl_s[0], scl_in};
    n.sda_s = {r.sda_s[0], sda_in};
    if (r.st == E_IDLE)
    begin
      if (cmd_valid_in)
      begin
        n.q    = 2'h0;
        n.cnt  = 8'h00;
        n.bitn = 4'h0;
        n.tx   = (cmd_in == CMD_WR) ? {wdata_in, 1'b1} : {8'hFF, rd_nack_in};
        if (cmd_in == CMD_START)
          n.st = E_START;
        else if (cmd_in == CMD_STOP)
          n.st = E_STOP;
        else
          n.st = E_BIT;
      end
    end
    else if (r.st == E_BIT && r.q == 2'h2 && !r.scl_s[1])
    begin
      // A slave holding the clock low stretches the low phase.
      n.cnt = 8'h00;
    end
    else if (r.cnt != QTR_CYC - 8'h01)
    begin
      n.cnt = r.cnt + 8'h01;
    end
    else
    begin
      n.cnt = 8'h00;
      n.q   = r.q + 2'h1;
      if (r.st == E_BIT && r.q == 2'h2)
        n.rx = {r.rx[7:0], r.sda_s[1]};
      if (r.q == 2'h3)
      begin
        if (r.st == E_BIT)
        begin
          n.tx   = {r.tx[7:0], 1'b1};
          n.bitn = r.bitn + 4'h1;
          if (r.bitn == 4'h8)
          begin
            n.st   = E_IDLE;
            n.done = 1'b1;
          end
        end
        else
        begin
          n.st   = E_IDLE;
          n.done = 1'b1;
        end
      end
    end
    // Pin drive derived from the next phase; data bits only move while the clock is low, start and stop move it with the clock high.
    if (n.st != E_IDLE)
    begin
      n.scl_oe = (n.q < 2'h2);
      if (n.q == 2'h0)
        n.sda_oe = r.sda_oe;
      else if (n.st == E_START)
        n.sda_oe = (n.q == 2'h3);
      else if (n.st == E_STOP)
        n.sda_oe = (n.q < 2'h3);
      else
        n.sda_oe = ~n.tx[8];
    end
  end

  // State register.
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      r <= '{st: E_IDLE, q: 2'h0, cnt: 8'h00, bitn: 4'h0, tx: 9'h1FF, rx: 9'h000,
             scl_oe: 1'b0, sda_oe: 1'b0, done: 1'b0, scl_s: 2'h3, sda_s: 2'h3};
    else
      r <= n;
  end

  // Command-side answers and pins.
  assign busy_out    = (r.st != E_IDLE);
  assign done_out    = r.done;
  assign rdata_out   = r.rx[8:1];
  assign ack_bit_out = r.rx[0];
  assign scl_oe_out  = r.scl_oe;
  assign sda_oe_out  = r.sda_oe;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_no_backoff: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (r.st == E_BIT && r.q != 2'h0) |-> (r.sda_oe == ~r.tx[8]))
    else $error("Data drive deviates from the bit being sent.");

  chk_stop_release: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (r.st == E_STOP && r.q == 2'h3 && r.cnt == QTR_CYC - 8'h01) |=> (!r.scl_oe && !r.sda_oe && r.done))
    else $error("Stop did not leave both lines released.");

endmodule : smbus_byte_engine

// ---- hdl/hp_smbus_master.sv ----
// Hot-plug expander SMBus master: EEPROM configuration load, then expander mirroring.
// Assumes hot-plug outputs and the software select come from logic on ref_clk_in.
`timescale 1ns/1ps
module hp_smbus_master
  import hp_smbus_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        arst_n_in,
  // Hot-plug values for ports 23 to 1
  input  wire logic [23:1] hp_ctl_in,
  output logic [23:1]      hp_status_out,
  // Pin 8 function select and raw pin
  input  wire logic        sw_irq_fn_sel_in,
  input  wire logic        gpio8_in,
  // Configuration result
  output logic [31:0]      cfg_out,
  output logic             cfg_done_out,
  output logic             ee_fail_out,
  // Master bus pins
  input  wire logic        master_bus_clock_in,
  output logic             master_bus_clock_out,
  output logic             master_bus_clock_oe_out,
  input  wire logic        master_bus_data_in,
  output logic             master_bus_data_out,
  output logic             master_bus_data_oe_out
);

  typedef struct packed {
    main_st_t    st;
    logic [3:0]  step;
    logic        pend;
    logic        nack;
    logic        ee_fail;
    logic [31:0] cfg;
    logic        cfg_done;
    logic [23:1] hp_stat;
    logic [23:1] shadow;
    logic [31:0] rbuf;
    logic [1:0]  gsync;
  } main_t;

  main_t       r, n;
  logic        eng_valid;
  logic        eng_busy;
  logic        eng_done;
  logic [7:0]  eng_rdata;
  logic        eng_ack;
  logic [10:0] op;
  logic [3:0]  last;
  logic        fn_en;
  logic        irq_act;

  // ****************************************************************
  // Sequence tables: {command, data byte, nack on read}.
  // ****************************************************************
  function automatic logic [10:0] step_op(main_st_t st, logic [3:0] step, logic [23:0] d);
    logic [10:0] o;
    o = {CMD_STOP, 8'h00, 1'b0};
    if (step == 4'h0 || (st != M_WR && step == 4'h3))
      o = {CMD_START, 8'h00, 1'b0};
    else if (step == 4'h1)
      o = {CMD_WR, ((st == M_EE) ? EE_ADDR : EXP_ADDR), 1'b0, 1'b0}; // Address byte with the write direction bit.
    else if (step == 4'h2)
      o = {CMD_WR, (st == M_EE) ? EE_OFFSET : ((st == M_WR) ? EXP_CMD_OUT : EXP_CMD_IN), 1'b0};
    else if (st == M_WR && step < WR_LAST)
      o = {CMD_WR, d[8 * (5 - int'(step)) +: 8], 1'b0};
    else if (step == 4'h4)
      o = {CMD_WR, (st == M_EE) ? EE_ADDR : EXP_ADDR, 1'b1, 1'b0};
    else if (st == M_EE && step < EE_LAST)
      o = {CMD_RD, 8'h00, step == EE_LAST - 4'h1};
    else if (st == M_RD && step < RD_LAST)
      o = {CMD_RD, 8'h00, step == RD_LAST - 4'h1};
    return o;
  endfunction : step_op

  // Pin 8 acts as the expander interrupt only when its alternate function is chosen.
  assign fn_en   = sw_irq_fn_sel_in | r.cfg[CFG_IRQ_BIT];
  assign irq_act = fn_en & ~r.gsync[1];
  assign op      = step_op(r.st, r.step, {r.shadow, 1'b0});
  assign last    = (r.st == M_EE) ? EE_LAST : ((r.st == M_WR) ? WR_LAST : RD_LAST);

  // ****************************************************************
  // Next state: boot load, then one transaction at a time.
  // ****************************************************************
  always_comb
  begin
    n         = r;
    eng_valid = 1'b0;
    n.gsync   = {r.gsync[0], gpio8_in};
    case (r.st)
      M_BOOT:
      begin
        n.st   = M_EE;
        n.step = 4'h0;
        n.nack = 1'b0;
      end
      M_IDLE:
      begin
        n.step = 4'h0;
        n.nack = 1'b0;
        if (hp_ctl_in != r.shadow)
        begin
          n.st     = M_WR;
          n.shadow = hp_ctl_in;
        end
        else if (irq_act)
          n.st = M_RD;
      end
      default:
      begin
        if (!r.pend)
        begin
          eng_valid = 1'b1;
          n.pend    = 1'b1;
        end
        else if (eng_done)
        begin
          n.pend = 1'b0;
          n.step = r.step + 4'h1;
          if (op[10:9] == CMD_RD)
            n.rbuf = {r.rbuf[23:0], eng_rdata};
          if (op[10:9] == CMD_WR && eng_ack)
          begin
            n.nack = 1'b1;
            n.step = last;
          end
          if (r.step == last)
          begin
            n.st = M_IDLE;
            if (r.st == M_EE)
            begin
              n.cfg_done = 1'b1;
              n.ee_fail  = r.nack;
              if (!r.nack)
                n.cfg = r.rbuf;
            end
            else if (r.st == M_RD && !r.nack)
              n.hp_stat = r.rbuf[23:1];
          end
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      r <= '{st: M_BOOT, step: 4'h0, pend: 1'b0, nack: 1'b0, ee_fail: 1'b0, cfg: CFG_DEFAULT,
             cfg_done: 1'b0, hp_stat: HP_RESET, shadow: HP_RESET, rbuf: CFG_DEFAULT, gsync: 2'h3};
    else
      r <= n;
  end

  // Byte engine on the dedicated master pins.
  smbus_byte_engine u_engine (
    .ref_clk_in   (ref_clk_in),
    .arst_n_in    (arst_n_in),
    .cmd_valid_in (eng_valid),
    .cmd_in       (op[10:9]),
    .wdata_in     (op[8:1]),
    .rd_nack_in   (op[0]),
    .busy_out     (eng_busy),
    .done_out     (eng_done),
    .rdata_out    (eng_rdata),
    .ack_bit_out  (eng_ack),
    .scl_in       (master_bus_clock_in),
    .sda_in       (master_bus_data_in),
    .scl_oe_out   (master_bus_clock_oe_out),
    .sda_oe_out   (master_bus_data_oe_out)
  );

  // Outputs; open-drain pins only ever drive low, on their own pins.
  assign master_bus_clock_out = 1'b0;
  assign master_bus_data_out  = 1'b0;
  assign hp_status_out        = r.hp_stat;
  assign cfg_out              = r.cfg;
  assign cfg_done_out         = r.cfg_done;
  assign ee_fail_out          = r.ee_fail;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_clock_quiet: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (r.st == M_IDLE || r.st == M_BOOT) |-> !master_bus_clock_oe_out)
    else $error("Bus clock driven outside a transaction.");

  chk_one_transfer: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    eng_valid |-> (!eng_busy ##1 eng_busy))
    else $error("Command issued while a transfer was running.");

  chk_write_all: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (r.st == M_IDLE && hp_ctl_in != r.shadow) |=> (r.st == M_WR && r.shadow == $past(hp_ctl_in)))
    else $error("Output change did not start a full write.");

  chk_irq_read: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (r.st == M_IDLE && hp_ctl_in == r.shadow && irq_act) |=> (r.st == M_RD))
    else $error("Expander interrupt did not start a read.");

  chk_port0_zero: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (eng_valid && r.st == M_WR && r.step == WR_LAST - 4'h1) |-> (op[8:1] == {r.shadow[7:1], 1'b0}))
    else $error("Last output byte does not carry ports 7 to 1 with port 0 as zero.");

  chk_load_first: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    !r.cfg_done |-> (r.st == M_BOOT || r.st == M_EE))
    else $error("Hot-plug traffic before configuration load.");

  chk_cfg_commit: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    $rose(r.cfg_done) |-> ($past(r.st) == M_EE && r.cfg == ($past(r.nack) ? CFG_DEFAULT : $past(r.rbuf))))
    else $error("Configuration not taken from the load.");

  chk_irq_gate: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (!sw_irq_fn_sel_in && !r.cfg[CFG_IRQ_BIT]) |-> !irq_act)
    else $error("Interrupt taken while pin 8 has another function.");

  cov_load: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in) $rose(r.cfg_done) && !r.ee_fail);
  cov_write: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in) r.st == M_WR ##1 r.st == M_IDLE);
  cov_read: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in) r.st == M_RD ##1 r.st == M_IDLE);

  // A refused load still ends and leaves the defaults in place.
  cov_load_fail: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in) $rose(r.cfg_done) && r.ee_fail);

endmodule : hp_smbus_master

// ---- sim/hp_bus_partner.sv ----
// Behavioural bus partners: the configuration EEPROM and the hot-plug expander.
// Assumes resolved open-drain levels at its inputs and pull-ups on both lines.
`timescale 1ns/1ps
module hp_bus_partner
  import hp_smbus_pkg::*;
(
  // Resolved bus lines and pulls
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             scl_pull_out,
  output logic             sda_pull_out,
  // Partner contents
  input  wire logic [31:0] ee_word_in,
  input  wire logic [23:1] exp_in_in,
  input  wire logic        slow_in,
  input  wire logic        ee_mute_in,
  // Expander side effects
  output logic             irq_n_out,
  output logic [23:0]      out_word_out,
  output int               wr_count_out,
  output int               rd_count_out
);
  // ****************************************************************
  // Frame state
  // ****************************************************************
  logic [3:0]  cnt      = 4'h0;
  logic [7:0]  sh       = 8'h00;
  logic [6:0]  dev      = 7'h00;
  logic        rd       = 1'b0;
  logic        sel      = 1'b0;
  logic        ack      = 1'b0;
  logic        nacked   = 1'b0;
  int          bidx     = 0;
  int          rdk      = 0;
  logic [7:0]  wbuf [0:3];
  logic [23:1] reported = 23'h00_0000;
  logic [31:0] src;

  // Outputs start released and counters empty.
  initial
  begin
    scl_pull_out = 1'b0;
    sda_pull_out = 1'b0;
    out_word_out = 24'h00_0000;
    wr_count_out = 0;
    rd_count_out = 0;
  end

  // The interrupt stays low while inputs differ from what was last read.
  assign irq_n_out = (exp_in_in == reported);

  // A falling data line with the clock high opens a frame.
  always @(negedge sda_in)
    if (scl_in === 1'b1)
    begin
      cnt = 4'h0;
      bidx = 0;
      rd = 1'b0;
      nacked = 1'b0;
      ack = 1'b0;
      rdk = 0;
    end

  // A rising data line with the clock high closes a frame.
  always @(posedge sda_in)
    if (scl_in === 1'b1 && bidx > 0)
    begin
      if (dev == EXP_ADDR && !rd && bidx == 5 && wbuf[0] == EXP_CMD_OUT)
      begin
        out_word_out = {wbuf[1], wbuf[2], wbuf[3]};
        wr_count_out++;
      end
      if (dev == EXP_ADDR && rd)
      begin
        rd_count_out++;
        reported = exp_in_in;
      end
      bidx = 0;
    end

  // Bits are taken on the rising clock; bytes are decoded after the eighth bit.
  always @(posedge scl_in)
  begin
    if (cnt == 4'h8)
    begin
      if (rd && !ack)
      begin
        nacked = nacked | sda_in;
        rdk = rdk + 1;
      end
      ack = 1'b0;
      cnt = 4'h0;
    end
    else
    begin
      sh = {sh[6:0], sda_in};
      cnt = cnt + 4'h1;
      if (cnt == 4'h8 && !(rd && bidx > 0))
      begin
        if (bidx == 0)
        begin
          dev = sh[7:1];
          rd = sh[0];
          sel = ((dev == EE_ADDR) && !ee_mute_in) || (dev == EXP_ADDR);
        end
        else if (bidx < 5)
          wbuf[bidx-1] = sh;
        ack = sel;
        bidx = bidx + 1;
      end
    end
  end

  // Data changes only while the clock is low; a slow partner also stretches it.
  always @(negedge scl_in)
  begin
    src = (dev == EE_ADDR) ? ee_word_in : {exp_in_in, 1'b1, 8'h00};
    if (cnt == 4'h8)
      sda_pull_out = ack;
    else if (rd && bidx > 0 && !nacked && rdk < 4)
      sda_pull_out = !src[31 - 8 * rdk - int'(cnt)];
    else
      sda_pull_out = 1'b0;
    if (slow_in)
    begin
      scl_pull_out = 1'b1;
      #5500;
      scl_pull_out = 1'b0;
    end
  end
endmodule : hp_bus_partner

// ---- sim/hp_smbus_master_bench.sv ----
// Self-checking bench for the hot-plug expander bus master.
// Assumes the partner model on the bus and pull-ups on both lines.
`timescale 1ns/1ps
module hp_smbus_master_bench;
  localparam logic [31:0] EE_WORD = 32'hC3A5_5A3E;
  localparam logic [23:1] IN_VAL  = 23'h12_3456;
  localparam logic [23:1] OUT_A   = 23'h2A_5C33;
  localparam logic [23:1] OUT_B   = 23'h55_0F0F;

  logic        ref_clk_in = 1'b0;
  logic        arst_n_in  = 1'b0;
  logic [23:1] hp_ctl     = 23'h00_0000;
  logic [23:1] exp_in     = 23'h00_0000;
  logic        sw_sel     = 1'b0;
  logic        slow       = 1'b0;
  logic        ee_mute    = 1'b0;
  logic        clk_o, data_o;
  logic [23:1] hp_status;
  logic [31:0] cfg;
  logic        cfg_done, ee_fail, clk_oe, data_oe, scl_pull, sda_pull, scl, sda, irq_n;
  logic [23:0] out_word;
  int          wr_count, rd_count, i;
  int          errors = 0;
  int          check_count = 0;
  int          cycles = 0;

  // Open-drain lines resolve high unless someone pulls them.
  assign scl = ~clk_oe & ~scl_pull;
  assign sda = ~data_oe & ~sda_pull;

  always #12.5 ref_clk_in = ~ref_clk_in;

  hp_smbus_master u_hp_smbus_master (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .hp_ctl_in(hp_ctl), .hp_status_out(hp_status),
    .sw_irq_fn_sel_in(sw_sel), .gpio8_in(irq_n), .cfg_out(cfg), .cfg_done_out(cfg_done),
    .ee_fail_out(ee_fail), .master_bus_clock_in(scl), .master_bus_clock_out(clk_o),
    .master_bus_clock_oe_out(clk_oe), .master_bus_data_in(sda), .master_bus_data_out(data_o),
    .master_bus_data_oe_out(data_oe));

  // The partners only answer and stretch the clock; no second master shares the bus.
  hp_bus_partner u_hp_bus_partner (
    .scl_in(scl), .sda_in(sda), .scl_pull_out(scl_pull), .sda_pull_out(sda_pull),
    .ee_word_in(EE_WORD), .exp_in_in(exp_in), .slow_in(slow), .irq_n_out(irq_n),
    .ee_mute_in(ee_mute), .out_word_out(out_word), .wr_count_out(wr_count), .rd_count_out(rd_count));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_val

  task conclude;
    $display("Comparisons %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Configuration load after reset, then a quiet bus clock.
  task test_boot;
    logic idle;
    idle = 1'b1;
    for (i = 0; i < 40000 && cfg_done !== 1'b1; i++) @(posedge ref_clk_in);
    check_val(cfg_done, 1, "load completion");
    check_val(cfg, EE_WORD, "configuration word");
    check_val(ee_fail, 0, "load failure flag");
    check_val({clk_o, data_o}, 0, "open-drain drive levels");
    repeat (1000)
    begin
      @(posedge ref_clk_in);
      if (clk_oe !== 1'b0 || scl !== 1'b1) idle = 1'b0;
    end
    check_val(idle, 1, "bus clock idle");
    $display("test boot finished");
  endtask : test_boot

  // A change in mid-write waits, then a second full write follows.
  task test_write;
    @(posedge ref_clk_in);
    exp_in <= IN_VAL;
    hp_ctl <= OUT_A;
    repeat (2000) @(posedge ref_clk_in);
    hp_ctl <= OUT_B;
    for (i = 0; i < 20000 && wr_count < 1; i++) @(posedge ref_clk_in);
    check_val(wr_count, 1, "first write count");
    check_val(out_word, {OUT_A, 1'b0}, "first write data");
    for (i = 0; i < 20000 && wr_count < 2; i++) @(posedge ref_clk_in);
    check_val(wr_count, 2, "second write count");
    check_val(out_word, {OUT_B, 1'b0}, "second write data");
    check_val(rd_count, 0, "reads with pin function off");
    $display("test write finished");
  endtask : test_write

  // Enabling the pin function lets the pending interrupt fetch the inputs.
  task test_read;
    @(posedge ref_clk_in);
    slow <= 1'b1;
    sw_sel <= 1'b1;
    for (i = 0; i < 26000 && rd_count < 1; i++) @(posedge ref_clk_in);
    repeat (150) @(posedge ref_clk_in);
    check_val(rd_count, 1, "read count");
    check_val(hp_status, IN_VAL, "input status");
    check_val(irq_n, 1, "interrupt released");
    repeat (500) @(posedge ref_clk_in);
    check_val(rd_count, 1, "no further read");
    check_val(wr_count, 2, "no further write");
    $display("test read finished");
  endtask : test_read

  // A mid-run reset with a silent EEPROM ends the load early and keeps the defaults.
  task test_nack;
    @(posedge ref_clk_in);
    arst_n_in <= 1'b0;
    hp_ctl    <= 23'h00_0000;
    slow      <= 1'b0;
    ee_mute   <= 1'b1;
    repeat (20) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    for (i = 0; i < 8000 && cfg_done !== 1'b1; i++) @(posedge ref_clk_in);
    check_val(cfg_done, 1, "load end after refusal");
    check_val(ee_fail, 1, "load failure flag set");
    check_val(cfg, hp_smbus_pkg::CFG_DEFAULT, "defaults kept");
    check_val(hp_status, hp_smbus_pkg::HP_RESET, "status after reset");
    repeat (200) @(posedge ref_clk_in);
    check_val(wr_count, 2, "no write of unchanged outputs");
    check_val(rd_count, 1, "no read with interrupt idle");
    $display("test nack finished");
  endtask : test_nack

  // ****************************************************************
  // Main sequence and cycle limit
  // ****************************************************************
  always @(posedge ref_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 99000)
    begin
      errors++;
      $display("CHECK FAILED at %0t: run exceeded its cycle limit", $time);
      conclude();
    end
  end

  initial
  begin
    repeat (20) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    test_boot();
    test_write();
    test_read();
    test_nack();
    conclude();
  end
endmodule : hp_smbus_master_bench
